// *** hw/cfg_regs_pkg.sv ***
/*
 configuration register bank constants: indexes, reset values, write masks,
 field positions and the carrier structs shared by the bank.
 assumes one 8-bit index/data access path from the host side.
*/
package cfg_regs_pkg;
	// register indexes
	localparam logic [7:0] IDX_KBC_RTC = 8'h05;
	localparam logic [7:0] IDX_POWER = 8'h06;
	localparam logic [7:0] IDX_TIMEOUT = 8'h07;
	localparam logic [7:0] IDX_CHIP_ID = 8'h08;
	localparam logic [7:0] IDX_ADV = 8'h09;
	localparam logic [7:0] IDX_CS0_LOW = 8'h0a;
	// values after reset
	localparam logic [7:0] RST_KBC_RTC = 8'h01;
	localparam logic [7:0] RST_POWER = 8'h00;
	localparam logic [7:0] RST_TIMEOUT = 8'h00;
	localparam logic [7:0] RST_ADV = 8'hc0;
	localparam logic [7:0] RST_CS0_LOW = 8'h00;
	// writable bits; reserved bits stay zero
	localparam logic [7:0] MASK_KBC_RTC = 8'hff;
	localparam logic [7:0] MASK_POWER = 8'h67;
	localparam logic [7:0] MASK_TIMEOUT = 8'h04;
	localparam logic [7:0] MASK_ADV = 8'he7;
	localparam logic [7:0] MASK_CS0_LOW = 8'hff;
	// kbc_rtc_control fields
	localparam int KRR_KBC_EN = 0;
	localparam int KRR_FAST = 1;
	localparam int KRR_PAE = 2;
	localparam int KRR_RTC_EN = 3;
	localparam int KRR_CLK_TEST = 4;
	localparam int KRR_RAM_BANK = 5;
	localparam int KRR_DECODE = 6;
	localparam int KRR_SYSTEM_CLOCK_INPUT = 7;
	// power_float_control fields
	localparam int PMC_IDE = 0;
	localparam int PMC_FDC = 1;
	localparam int PMC_UART = 2;
	localparam int PMC_LOCK = 5;
	localparam int PMC_PP = 6;
	// timeout_irq_config and advanced_pin_config fields
	localparam int TUP_EPP_IRQ = 2;
	localparam int ASC_ALT_RATE = 0;
	localparam int ASC_DRIVE23_SELECT = 1;
	localparam int ASC_TDR = 2;
	localparam int ASC_ECP_BIT = 5;
	localparam int ASC_MODE_LO = 6;
	localparam logic [1:0] MODE_ILLEGAL = 2'h2;
	// on-chip kbc decode ports
	localparam logic [9:0] KBC_DATA_PORT = 10'h060;
	localparam logic [9:0] KBC_CMD_PORT = 10'h064;
	// oscillator dividers for the kbc clock
	localparam int KBC_DIV_SLOW = 3;
	localparam int KBC_DIV_FAST = 2;
	// whole state of the bank
	typedef struct packed {
		logic [7:0] kbc_rtc_control;
		logic [7:0] power_float_control;
		logic [7:0] timeout_irq_config;
		logic [7:0] advanced_pin_config;
		logic [7:0] cs0;
		logic [7:0] rd_data;
		logic rd_valid;
		logic [1:0] div_cnt;
		logic kbc_tick;
	} cfg_state_t;
	// per-function float controls
	typedef struct packed {
		logic ide_float;
		logic ide_buf_off;
		logic fdc_float;
		logic [1:0] uart_float;
		logic pp_float;
	} pin_float_t;
endpackage

// *** hw/superio_config_regs_05_0a.sv ***
/*
 configuration registers 05h..0ah: kbc/rtc control, output float control,
 timeout irq enable, chip id, advanced pin options, cs0 low address.
 assumes the host index/data decode in front of it delivers one-cycle
 read and write strobes with the selected index, all synchronous to clk_sys.
*/
`timescale 1ns/1ps
module superio_config_regs_05_0a
	import cfg_regs_pkg::*;
#(
	parameter int DIV_SLOW = KBC_DIV_SLOW,
	parameter int DIV_FAST = KBC_DIV_FAST,
	parameter logic [7:0] CHIP_ID = 8'h5a // arbitrary value
)
(
	// clock and resets
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic power_good,
	// configuration access
	input wire logic [7:0] cfg_index,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	output logic cfg_rvalid,
	// locking
	input wire logic global_lock,
	output logic selective_lock,
	// keyboard controller
	input wire logic system_clock_input,
	input wire logic cs_n,
	input wire logic [9:0] isa_addr,
	output logic kbc_clk_en,
	output logic kbc_pins_hold,
	output logic kbc_sel,
	output logic kbc_reg_sel,
	output logic program_access_enable,
	// real-time clock
	input wire logic rtc_irq_req,
	input wire logic rtc_clk32k,
	input wire logic [6:0] rtc_addr_in,
	output logic rtc_enable,
	output logic irq8_out,
	output logic irq8_oe,
	output logic sync_out,
	output logic sync_oe,
	output logic [7:0] rtc_ram_addr,
	// function float control
	input wire logic ide_disabled,
	input wire logic fdc_disabled,
	input wire logic [1:0] uart_disabled,
	input wire logic pp_disabled,
	input wire logic power_down,
	output pin_float_t float_ctl,
	// parallel port interrupt
	input wire logic pp_irq_in,
	input wire logic epp_timeout,
	input wire logic irq_invert,
	input wire logic irq_open_drain,
	input wire logic pp_irq_sel7,
	input wire logic rate_out0,
	output logic irq5_out,
	output logic irq5_oe,
	output logic irq7_out,
	output logic irq7_oe,
	// floppy pin options
	input wire logic [1:0] drive_sel,
	input wire logic drive_type_input,
	input wire logic iocs16_in,
	output logic drive23_select_n,
	output logic drive23_oe,
	output logic drive_type_eff,
	output logic tape_drive_full,
	output logic iocs16_eff,
	// ecp mirror, mode and cs0 low address
	output logic ecp_config_a_bit3,
	output logic [1:0] system_mode,
	output logic [7:0] cs0_low_addr
);
	// refuse divider values the 2-bit counter cannot serve
	if (DIV_SLOW < 2 || DIV_SLOW > 4 || DIV_FAST < 2 || DIV_FAST > 4)
	begin : g_div_check
		$error("kbc divider out of range 2..4");
	end

	localparam logic [1:0] DIV_SLOW_MAX = 2'(DIV_SLOW - 1);
	localparam logic [1:0] DIV_FAST_MAX = 2'(DIV_FAST - 1);

	cfg_state_t st_q; // registered state
	cfg_state_t st_d; // next state
	logic [7:0] m; // effective write mask for 05h, 06h and 09h
	logic [1:0] div_max; // current divider wrap
	logic pp_req; // parallel port irq request
	logic pp_lvl; // after polarity
	logic pp_oe; // configured line drive
	logic pp_out;
	logic use_irq7;

	// index decode, used by the read path valid flag
	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = (idx >= IDX_KBC_RTC) && (idx <= IDX_CS0_LOW);
	endfunction

	// masked merge of written data into a register
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
		input logic [7:0] mask);
		merge = (old & ~mask) | (val & mask);
	endfunction

	// next-state logic
	always_comb
	begin
		st_d = st_q;
		m = 8'h00;
		div_max = st_q.kbc_rtc_control[KRR_FAST] ? DIV_FAST_MAX : DIV_SLOW_MAX;
		// writes; global lock from the test register blocks all of them
		if (cfg_wr && !global_lock)
		begin
			case (cfg_index)
				IDX_KBC_RTC:
				begin
					m = MASK_KBC_RTC;
					if (st_q.power_float_control[PMC_LOCK])
						m[KRR_RAM_BANK] = 1'b0;
					// source switch only with kbc off, avoids a runt clock
					if (st_q.kbc_rtc_control[KRR_KBC_EN])
						m[KRR_SYSTEM_CLOCK_INPUT] = 1'b0;
					st_d.kbc_rtc_control = merge(st_q.kbc_rtc_control, cfg_wdata, m);
				end
				IDX_POWER:
				begin
					m = MASK_POWER;
					if (st_q.power_float_control[PMC_LOCK])
						m[PMC_LOCK] = 1'b0;
					st_d.power_float_control = merge(st_q.power_float_control, cfg_wdata, m);
				end
				IDX_TIMEOUT:
					st_d.timeout_irq_config = merge(st_q.timeout_irq_config, cfg_wdata, MASK_TIMEOUT);
				IDX_ADV:
				begin
					// reserved bit 3 is not stored
					m = MASK_ADV;
					if (cfg_wdata[ASC_MODE_LO+:2] == MODE_ILLEGAL)
						m[ASC_MODE_LO+:2] = 2'b00;
					st_d.advanced_pin_config = merge(st_q.advanced_pin_config, cfg_wdata, m);
				end
				IDX_CS0_LOW:
					st_d.cs0 = merge(st_q.cs0, cfg_wdata, MASK_CS0_LOW);
				default:
					m = 8'h00; // id and unmapped: no effect
			endcase
		end
		// power-good low overrides any write to the kbc/rtc control register
		if (!power_good)
			st_d.kbc_rtc_control = RST_KBC_RTC;
		// read path, registered; unmapped answers no valid
		st_d.rd_valid = cfg_rd && is_mapped(cfg_index);
		if (cfg_rd)
		begin
			case (cfg_index)
				IDX_KBC_RTC: st_d.rd_data = st_q.kbc_rtc_control;
				IDX_POWER: st_d.rd_data = st_q.power_float_control;
				IDX_TIMEOUT: st_d.rd_data = st_q.timeout_irq_config;
				IDX_CHIP_ID: st_d.rd_data = CHIP_ID;
				IDX_ADV: st_d.rd_data = st_q.advanced_pin_config;
				IDX_CS0_LOW: st_d.rd_data = st_q.cs0;
				default: st_d.rd_data = 8'h00;
			endcase
		end
		// kbc clock enable: divider on oscillator, else system clock pulses
		if (!st_q.kbc_rtc_control[KRR_KBC_EN])
		begin
			st_d.div_cnt = 2'd0;
			st_d.kbc_tick = 1'b0;
		end
		else if (st_q.kbc_rtc_control[KRR_SYSTEM_CLOCK_INPUT])
		begin
			st_d.div_cnt = 2'd0;
			st_d.kbc_tick = system_clock_input;
		end
		else if (st_q.div_cnt >= div_max)
		begin
			st_d.div_cnt = 2'd0;
			st_d.kbc_tick = 1'b1;
		end
		else
		begin
			st_d.div_cnt = st_q.div_cnt + 2'd1;
			st_d.kbc_tick = 1'b0;
		end
	end

	// state register, synchronous reset
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_q.kbc_rtc_control <= RST_KBC_RTC;
			st_q.power_float_control <= RST_POWER;
			st_q.timeout_irq_config <= RST_TIMEOUT;
			st_q.advanced_pin_config <= RST_ADV;
			st_q.cs0 <= RST_CS0_LOW;
			st_q.rd_data <= 8'h00;
			st_q.rd_valid <= 1'b0;
			st_q.div_cnt <= 2'd0;
			st_q.kbc_tick <= 1'b0;
		end
		else
			st_q <= st_d;
	end

	// access and kbc outputs
	assign cfg_rdata = st_q.rd_data;
	assign cfg_rvalid = st_q.rd_valid;
	assign selective_lock = st_q.power_float_control[PMC_LOCK];
	assign kbc_clk_en = st_q.kbc_tick;
	assign kbc_pins_hold = !st_q.kbc_rtc_control[KRR_KBC_EN];
	assign program_access_enable = st_q.kbc_rtc_control[KRR_PAE];
	assign kbc_reg_sel = isa_addr[2];
	// kbc select: chip select pin or internal port decode
	assign kbc_sel = st_q.kbc_rtc_control[KRR_KBC_EN] && (st_q.kbc_rtc_control[KRR_DECODE] ?
		(isa_addr == KBC_DATA_PORT || isa_addr == KBC_CMD_PORT) : !cs_n);

	// rtc outputs
	assign rtc_enable = st_q.kbc_rtc_control[KRR_RTC_EN];
	assign irq8_oe = st_q.kbc_rtc_control[KRR_RTC_EN];
	assign irq8_out = st_q.kbc_rtc_control[KRR_RTC_EN] && rtc_irq_req;
	assign sync_oe = st_q.kbc_rtc_control[KRR_CLK_TEST];
	assign sync_out = st_q.kbc_rtc_control[KRR_CLK_TEST] && rtc_clk32k;
	assign rtc_ram_addr = {st_q.kbc_rtc_control[KRR_RAM_BANK], rtc_addr_in};

	// float controls; interrupt lines are never part of these
	assign float_ctl.ide_float = st_q.power_float_control[PMC_IDE] && (ide_disabled || power_down);
	assign float_ctl.ide_buf_off = float_ctl.ide_float;
	assign float_ctl.fdc_float = st_q.power_float_control[PMC_FDC] && (fdc_disabled || power_down);
	assign float_ctl.uart_float = {2{st_q.power_float_control[PMC_UART]}} &
		(uart_disabled | {2{power_down}});
	assign float_ctl.pp_float = st_q.power_float_control[PMC_PP] && (pp_disabled || power_down);

	// parallel port interrupt with polarity and drive type
	always_comb
	begin
		pp_req = pp_irq_in || (epp_timeout && st_q.timeout_irq_config[TUP_EPP_IRQ]);
		pp_lvl = pp_req ^ irq_invert;
		pp_oe = irq_open_drain ? !pp_lvl : 1'b1;
		pp_out = irq_open_drain ? 1'b0 : pp_lvl;
		use_irq7 = st_q.advanced_pin_config[ASC_ALT_RATE] || pp_irq_sel7;
		irq7_oe = use_irq7 && pp_oe;
		irq7_out = use_irq7 && pp_out;
		if (st_q.advanced_pin_config[ASC_ALT_RATE])
		begin
			irq5_oe = !rate_out0;
			irq5_out = 1'b0;
		end
		else
		begin
			irq5_oe = !use_irq7 && pp_oe;
			irq5_out = !use_irq7 && pp_out;
		end
	end

	// floppy pin options; drive23 undefined in four-drive encoding
	assign drive23_oe = st_q.advanced_pin_config[ASC_DRIVE23_SELECT];
	assign drive23_select_n = !(st_q.advanced_pin_config[ASC_DRIVE23_SELECT] && drive_sel[1]);
	assign drive_type_eff = st_q.advanced_pin_config[ASC_DRIVE23_SELECT] || drive_type_input;
	assign tape_drive_full = st_q.advanced_pin_config[ASC_TDR];
	assign iocs16_eff = st_q.advanced_pin_config[ASC_TDR] || iocs16_in;
	assign ecp_config_a_bit3 = st_q.advanced_pin_config[ASC_ECP_BIT];
	assign system_mode = st_q.advanced_pin_config[ASC_MODE_LO+:2];
	assign cs0_low_addr = st_q.cs0;

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_pg_init;
		!power_good |=> st_q.kbc_rtc_control == RST_KBC_RTC;
	endproperty
	a_pg_init: assert property (p_pg_init) else $error("kbc control not 01h");

	property p_frozen;
		!st_q.kbc_rtc_control[KRR_KBC_EN] |=> !kbc_clk_en;
	endproperty
	a_frozen: assert property (p_frozen) else $error("kbc clock runs disabled");

	property p_div3;
		(kbc_clk_en && st_q.kbc_rtc_control[KRR_KBC_EN] && !st_q.kbc_rtc_control[KRR_SYSTEM_CLOCK_INPUT] && !st_q.kbc_rtc_control[KRR_FAST])
		##1 $stable(st_q.kbc_rtc_control)[*3] |-> kbc_clk_en && !$past(kbc_clk_en)
		&& !$past(kbc_clk_en, 2);
	endproperty
	a_div3: assert property (p_div3) else $error("kbc slow divider wrong");

	property p_rtc_off;
		!st_q.kbc_rtc_control[KRR_RTC_EN] |-> !irq8_oe && !rtc_enable;
	endproperty
	a_rtc_off: assert property (p_rtc_off) else $error("irq8 driven");

	property p_sync;
		sync_oe == st_q.kbc_rtc_control[KRR_CLK_TEST] && (!sync_oe || sync_out == rtc_clk32k);
	endproperty
	a_sync: assert property (p_sync) else $error("sync pin wrong");

	property p_bank;
		rtc_ram_addr[7] == st_q.kbc_rtc_control[KRR_RAM_BANK] && rtc_ram_addr[6:0] == rtc_addr_in;
	endproperty
	a_bank: assert property (p_bank) else $error("rtc bank wrong");

	property p_kbc_cs;
		(st_q.kbc_rtc_control[KRR_KBC_EN] && !st_q.kbc_rtc_control[KRR_DECODE]) |-> kbc_sel == !cs_n;
	endproperty
	a_kbc_cs: assert property (p_kbc_cs) else $error("kbc select wrong");

	property p_lock;
		(st_q.power_float_control[PMC_LOCK] && cfg_wr && cfg_index == IDX_KBC_RTC && power_good)
		|=> $stable(st_q.kbc_rtc_control[KRR_RAM_BANK]) && st_q.power_float_control[PMC_LOCK];
	endproperty
	a_lock: assert property (p_lock) else $error("locked bit changed");

	property p_ide;
		float_ctl.ide_float == (st_q.power_float_control[PMC_IDE] && (ide_disabled || power_down));
	endproperty
	a_ide: assert property (p_ide) else $error("ide float wrong");

	property p_id;
		(cfg_rd && cfg_index == IDX_CHIP_ID) |=> cfg_rvalid && cfg_rdata == CHIP_ID;
	endproperty
	a_id: assert property (p_id) else $error("chip id read wrong");

	property p_alt5;
		st_q.advanced_pin_config[ASC_ALT_RATE] |-> irq5_oe == !rate_out0 && !irq5_out;
	endproperty
	a_alt5: assert property (p_alt5) else $error("irq5 not rate copy");

	property p_mode;
		(cfg_wr && !global_lock && cfg_index == IDX_ADV && cfg_wdata[7:6] == MODE_ILLEGAL)
		|=> $stable(system_mode);
	endproperty
	a_mode: assert property (p_mode) else $error("illegal mode stored");

endmodule // superio_config_regs_05_0a

// *** verif/cfg_host_model.sv ***
/*
 host model: index/data configuration cycles toward the bank.
 assumes strobes are sampled on the rising edge of clk_sys.
*/
`timescale 1ns/1ps
module cfg_host_model
	import cfg_regs_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// access path
	output logic [7:0] cfg_index,
	output logic cfg_wr,
	output logic cfg_rd,
	output logic [7:0] cfg_wdata,
	input wire logic [7:0] cfg_rdata,
	input wire logic cfg_rvalid
);
	// idle bus at time zero
	initial
	begin
		cfg_index = 8'h00;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_wdata = 8'h00;
	end
	// one-cycle write; reserved advanced bit always sent as zero
	task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
		@(posedge clk_sys);
		#1;
		cfg_index = idx;
		cfg_wdata = (idx == IDX_ADV) ? (dat & 8'hf7) : dat;
		cfg_wr = 1'b1;
		@(posedge clk_sys);
		#1;
		cfg_wr = 1'b0;
		cfg_wdata = ~cfg_wdata; // stale data must not look valid
	endtask
	// one-cycle read; answer taken one edge later
	task automatic rd(input logic [7:0] idx, output logic [7:0] dat, output logic vld);
		@(posedge clk_sys);
		#1;
		cfg_index = idx;
		cfg_rd = 1'b1;
		@(posedge clk_sys);
		#1;
		cfg_rd = 1'b0;
		dat = cfg_rdata;
		vld = cfg_rvalid;
	endtask
endmodule // cfg_host_model

// *** verif/superio_config_regs_05_0a_tb_top.sv ***
/*
 testbench for configuration registers 05h..0ah.
 assumes the host model performs every register cycle.
*/
`timescale 1ns/1ps
module superio_config_regs_05_0a_tb_top
	import cfg_regs_pkg::*;
;
	localparam logic [7:0] ID = 8'h3c; // arbitrary value
	logic clk_sys, rst_n, power_good, global_lock, system_clock_input, cs_n;
	logic [9:0] isa_addr;
	logic rtc_irq_req, rtc_clk32k, ide_disabled, fdc_disabled, pp_disabled, power_down;
	logic [6:0] rtc_addr_in;
	logic [1:0] uart_disabled, drive_sel, system_mode;
	logic pp_irq_in, epp_timeout, irq_invert, irq_open_drain, pp_irq_sel7, rate_out0;
	logic drive_type_input, iocs16_in, cfg_wr, cfg_rd, cfg_rvalid, selective_lock;
	logic [7:0] cfg_index, cfg_wdata, cfg_rdata, rtc_ram_addr, cs0_low_addr, d;
	logic kbc_clk_en, kbc_pins_hold, kbc_sel, kbc_reg_sel, program_access_enable, v;
	logic rtc_enable, irq8_out, irq8_oe, sync_out, sync_oe, irq5_out, irq5_oe;
	logic irq7_out, irq7_oe, drive23_select_n, drive23_oe, drive_type_eff;
	logic tape_drive_full, iocs16_eff, ecp_config_a_bit3;
	pin_float_t float_ctl;
	int n_errors, checks_done;
	superio_config_regs_05_0a #(.CHIP_ID(ID)) dut (.clk_sys, .rst_n, .power_good,
		.cfg_index, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .global_lock,
		.selective_lock, .system_clock_input, .cs_n, .isa_addr, .kbc_clk_en, .kbc_pins_hold,
		.kbc_sel, .kbc_reg_sel, .program_access_enable, .rtc_irq_req, .rtc_clk32k,
		.rtc_addr_in, .rtc_enable, .irq8_out, .irq8_oe, .sync_out, .sync_oe, .rtc_ram_addr,
		.ide_disabled, .fdc_disabled, .uart_disabled, .pp_disabled, .power_down, .float_ctl,
		.pp_irq_in, .epp_timeout, .irq_invert, .irq_open_drain, .pp_irq_sel7, .rate_out0,
		.irq5_out, .irq5_oe, .irq7_out, .irq7_oe, .drive_sel, .drive_type_input, .iocs16_in,
		.drive23_select_n, .drive23_oe, .drive_type_eff, .tape_drive_full, .iocs16_eff,
		.ecp_config_a_bit3, .system_mode, .cs0_low_addr);
	cfg_host_model host (.clk_sys, .cfg_index, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata,
		.cfg_rvalid);
	// compare and count
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// read a register and expect a valid answer
	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
		host.rd(idx, d, v);
		check("rdata", d, exp);
		check("rvalid", {7'h0, v}, 8'h01);
	endtask
	// count kbc ticks over 30 cycles after settling
	task automatic pulses(input int exp);
		int n;
		n = 0;
		repeat (4) @(posedge clk_sys);
		repeat (30)
		begin
			@(posedge clk_sys);
			#1;
			if (kbc_clk_en === 1'b1)
				n++;
		end
		check("kbc ticks", n[7:0], exp[7:0]);
	endtask
	// synchronous reset, 8 cycles
	task automatic do_reset;
		rst_n = 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
	endtask
	// reset values, id register, unmapped index
	task automatic t_reset;
		rchk(IDX_KBC_RTC, 8'h01);
		rchk(IDX_POWER, 8'h00);
		rchk(IDX_ADV, 8'hc0);
		rchk(IDX_CHIP_ID, ID);
		host.wr(IDX_CHIP_ID, ~ID);
		rchk(IDX_CHIP_ID, ID);
		host.rd(8'h0b, d, v);
		check("unmapped rvalid", {7'h0, v}, 8'h00);
	endtask
	// kbc/rtc control fields and power-good reload
	task automatic t_kbc_rtc;
		host.wr(IDX_KBC_RTC, 8'h7d);
		rchk(IDX_KBC_RTC, 8'h7d);
		check("ram addr", rtc_ram_addr, 8'h95);
		check("irq8", {6'h0, irq8_oe, irq8_out}, 8'h03);
		check("sync", {6'h0, sync_oe, sync_out}, 8'h03);
		check("kbc sel", {6'h0, kbc_sel, kbc_reg_sel}, 8'h03);
		isa_addr = 10'h065;
		#1;
		check("kbc sel off", {7'h0, kbc_sel}, 8'h00);
		host.wr(IDX_KBC_RTC, 8'h75);
		check("irq8 float", {7'h0, irq8_oe}, 8'h00);
		@(posedge clk_sys);
		#1;
		power_good = 1'b0;
		@(posedge clk_sys);
		#1;
		power_good = 1'b1;
		rchk(IDX_KBC_RTC, 8'h01);
	endtask
	// kbc clock divide, freeze and source select
	task automatic t_clock;
		pulses(30 / KBC_DIV_SLOW);
		host.wr(IDX_KBC_RTC, 8'h03);
		pulses(30 / KBC_DIV_FAST);
		host.wr(IDX_KBC_RTC, 8'h83);
		rchk(IDX_KBC_RTC, 8'h03);
		host.wr(IDX_KBC_RTC, 8'h00);
		check("pins hold", {7'h0, kbc_pins_hold}, 8'h01);
		pulses(0);
		host.wr(IDX_KBC_RTC, 8'h80);
		host.wr(IDX_KBC_RTC, 8'h83);
		pulses(30);
	endtask
	// float controls, then the selective lock
	task automatic t_float_lock;
		host.wr(IDX_POWER, 8'hff);
		rchk(IDX_POWER, MASK_POWER);
		ide_disabled = 1'b1;
		uart_disabled = 2'b01;
		#1;
		check("float", {2'h0, float_ctl}, 8'h32);
		power_down = 1'b1;
		#1;
		check("float down", {2'h0, float_ctl}, 8'h3f);
		host.wr(IDX_POWER, 8'h00);
		rchk(IDX_POWER, 8'h20);
		check("float off", {2'h0, float_ctl}, 8'h00);
		host.wr(IDX_KBC_RTC, 8'ha3);
		rchk(IDX_KBC_RTC, 8'h83);
		do_reset();
		rchk(IDX_POWER, 8'h00);
	endtask
	// advanced pin options and system mode
	task automatic t_adv;
		host.wr(IDX_ADV, 8'h27);
		rchk(IDX_ADV, 8'h27);
		check("ecp", {7'h0, ecp_config_a_bit3}, 8'h01);
		check("tape", {6'h0, tape_drive_full, iocs16_eff}, 8'h03);
		check("drv type", {6'h0, drive_type_eff, drive23_select_n}, 8'h02);
		check("irq5", {6'h0, irq5_oe, irq5_out}, 8'h02);
		check("irq7", {7'h0, irq7_out}, 8'h01);
		rate_out0 = 1'b1;
		#1;
		check("irq5 off", {7'h0, irq5_oe}, 8'h00);
		for (int i = 3; i >= 0; i--)
			if (i != 2)
			begin
				host.wr(IDX_ADV, {i[1:0], 6'h00});
				check("mode", {6'h0, system_mode}, {6'h0, i[1:0]});
			end
		// last legal mode was 00; illegal 10 must leave it there
		host.wr(IDX_ADV, 8'h80);
		rchk(IDX_ADV, 8'h00);
		host.wr(IDX_ADV, 8'h00);
	endtask
	// epp timeout interrupt enable
	task automatic t_timeout;
		host.wr(IDX_TIMEOUT, 8'hff);
		rchk(IDX_TIMEOUT, 8'h04);
		check("epp irq", {7'h0, irq5_out}, 8'h01);
		host.wr(IDX_TIMEOUT, 8'h00);
		check("epp mask", {7'h0, irq5_out}, 8'h00);
	endtask
	// cs0 low address, global lock, chip select kbc access
	task automatic t_misc;
		rchk(IDX_CS0_LOW, 8'h00);
		host.wr(IDX_CS0_LOW, 8'ha5);
		rchk(IDX_CS0_LOW, 8'ha5);
		check("cs0 pins", cs0_low_addr, 8'ha5);
		// global lock blocks every write
		global_lock = 1'b1;
		host.wr(IDX_CS0_LOW, 8'h5a);
		global_lock = 1'b0;
		rchk(IDX_CS0_LOW, 8'ha5);
		// krr is 01h here: kbc enabled, chip select decode
		check("pae rtc", {6'h0, program_access_enable, rtc_enable}, 8'h00);
		cs_n = 1'b0;
		#1;
		check("kbc cs sel", {7'h0, kbc_sel}, 8'h01);
		cs_n = 1'b1;
		#1;
		check("kbc cs off", {7'h0, kbc_sel}, 8'h00);
	endtask
	// verdict and end of run
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// 200 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// hang guard, far beyond the expected run
	initial
	begin
		#20000;
		n_errors++;
		finish_test();
	end
	// main sequence
	initial
	begin
		{power_good, cs_n, rtc_irq_req, rtc_clk32k, system_clock_input} = 5'h1f;
		{global_lock, ide_disabled, fdc_disabled, pp_disabled, power_down} = 5'h00;
		{pp_irq_in, epp_timeout, irq_invert, irq_open_drain, pp_irq_sel7} = 5'h18;
		{rate_out0, drive_type_input, iocs16_in, uart_disabled} = 5'h00;
		drive_sel = 2'b10;
		isa_addr = 10'h064;
		rtc_addr_in = 7'h15;
		n_errors = 0;
		checks_done = 0;
		do_reset();
		t_reset();
		t_kbc_rtc();
		t_clock();
		t_float_lock();
		t_adv();
		pp_irq_in = 1'b0;
		t_timeout();
		t_misc();
		finish_test();
	end
endmodule // superio_config_regs_05_0a_tb_top
